// ### inc/rtcs_regs.svh
// Constants of the real-time-clock two-wire slave port
`ifndef RTCS_REGS_SVH
`define RTCS_REGS_SVH

// Register map
`define RTCS_TIME_BYTES   7
`define RTCS_CTRL_ADDR    6'h07
`define RTCS_PTR_LAST     6'h3f
`define RTCS_HALT_BIT     7
`define RTCS_CTRL_OUT     7
`define RTCS_CTRL_SQUARE_WAVE_ENABLE    4
`define RTCS_CTRL_RS_HI   1
`define RTCS_CTRL_RS_LO   0

// Bits per byte before the ninth (acknowledge) clock
`define RTCS_BYTE_BITS    4'h8

// Divider taps, oscillator tick at 65.536 kHz
`define RTCS_TAP_1HZ      15
`define RTCS_TAP_4K       3
`define RTCS_TAP_8K       2
`define RTCS_TAP_32K      0

// Standard bus speed and sampling rate
`define RTCS_MCLK_KHZ     100000
`define RTCS_SCL_MAX_KHZ  100
`define RTCS_SCL_SAMPLES  (`RTCS_MCLK_KHZ / `RTCS_SCL_MAX_KHZ)

`endif

// ### inc/rtcs_pkg.sv
// Types of the real-time-clock two-wire slave port
package rtcs_pkg;

    // Bus-side sequencer states, one-hot
    typedef enum logic [6:0] {
        RTCS_IDLE   = 7'h01,    // Bus free or after STOP
        RTCS_ADDR   = 7'h02,    // Shifting in address byte
        RTCS_ACK    = 7'h04,    // Driving acknowledge
        RTCS_RXD    = 7'h08,    // Shifting in pointer or data
        RTCS_TXD    = 7'h10,    // Shifting out data
        RTCS_RACK   = 7'h20,    // Master acknowledge slot
        RTCS_IGNORE = 7'h40     // Not addressed or read not acked, wait for START
    } rtcs_state_e;

    // Write strobe toward the timekeeping core
    typedef struct packed {
        logic       valid;      // One-cycle pulse
        logic [5:0] addr;       // Register address
        logic [7:0] data;       // Written byte
    } rtcs_wr_s;

    // All state of the bus-side domain
    typedef struct packed {
        logic [63:0][7:0] mem;    // Register and RAM image
        logic [55:0]      shadow; // Time copy taken at START
        rtcs_state_e      state;  // Sequencer
        logic [2:0]       scl;    // Sync pair plus previous
        logic [2:0]       sda;    // Sync pair plus previous
        logic [3:0]       bits;   // Bits seen in this byte
        logic [7:0]       sh;     // Shift register
        logic [5:0]       ptr;    // Register pointer
        logic             rd;     // Read transfer
        logic             first;  // Next byte loads pointer
        logic             nack;   // Master withheld ack
        logic             sda_oe; // Pulling data line low
        rtcs_wr_s         wr;     // Write strobe
    } rtcs_link_s;

    // All state of the oscillator domain
    typedef struct packed {
        logic [1:0]  rst;       // Reset synchroniser
        logic [4:0]  c1;        // Control sync, first stage
        logic [4:0]  c2;        // Control sync, second stage
        logic [15:0] cnt;       // Divider chain
        logic        sqw;       // Square-wave pin level
    } rtcs_osc_s;

endpackage : rtcs_pkg

// ### design/rtcs_slave.sv
// Two-wire slave port with register file and square-wave divider
`timescale 1ns/10ps
`include "rtcs_regs.svh"

module rtcs_slave #(
    parameter logic [6:0] DEV_ADDR = 7'h2a  // Value arbitrary
) (
    input  wire logic            i_mclk,       // System clock
    input  wire logic            i_rst,        // Sync reset, high
    input  wire logic            i_osc_clk,    // Oscillator tick
    input  wire logic            i_scl,        // Bus clock pin
    input  wire logic            i_sda,        // Bus data pin level
    output logic                 o_sda_o,      // Data drive value
    output logic                 o_sda_oe,     // Data pull-down on
    input  wire logic [55:0]     i_time,       // Running time bytes
    output rtcs_pkg::rtcs_wr_s   o_wr,         // Register write
    output logic                 o_oscillator_halt, // Halt bit
    output logic                 o_square_wave_pin  // Square wave
);

    // Bus-side state and next state
    rtcs_pkg::rtcs_link_s q;
    rtcs_pkg::rtcs_link_s d;
    // Oscillator-side state and next state
    rtcs_pkg::rtcs_osc_s  s;
    rtcs_pkg::rtcs_osc_s  n;

    // Samples per bus bit at the highest legal bus rate
    localparam int SCL_SAMPLES = `RTCS_SCL_SAMPLES;

    // Edge and condition terms, from registered samples only
    logic       scl_rise;    // Clock went high
    logic       scl_fall;    // Clock went low
    logic       bus_start;   // START or repeated START
    logic       bus_stop;    // STOP
    logic       sda_now;     // Settled data sample
    logic       byte_done;   // Eighth bit shifted
    logic [7:0] rd_byte;     // Byte at the pointer
    logic       osc_rst;     // Reset in oscillator domain
    logic [4:0] ctl;         // Control bits to cross
    logic       scl_lo;      // Settled clock is low

    // The first sync stage is never looked at here
    assign scl_rise  = q.scl[1] & ~q.scl[2];
    assign scl_fall  = ~q.scl[1] & q.scl[2];
    assign bus_start = q.scl[1] & q.scl[2] & q.sda[2] & ~q.sda[1];
    assign bus_stop  = q.scl[1] & q.scl[2] & ~q.sda[2] & q.sda[1];
    assign sda_now   = q.sda[1];
    assign scl_lo    = ~q.scl[1];
    assign byte_done = (q.bits == `RTCS_BYTE_BITS);

    // Time registers read from the shadow copy
    assign rd_byte = (q.ptr < 6'(`RTCS_TIME_BYTES))
                   ? q.shadow[{q.ptr[2:0], 3'h0} +: 8]
                   : q.mem[q.ptr];

    // Bus-side next-state logic
    always_comb begin
        d          = q;
        // Two flops per pin; a third copy gives edges.
        // Far faster than any standard-speed clock bit.
        d.scl      = {q.scl[1:0], i_scl};
        d.sda      = {q.sda[1:0], i_sda};
        d.wr.valid = 1'b0;
        if (bus_start) begin
            // Repeated START restarts the address phase
            d.state  = rtcs_pkg::RTCS_ADDR;
            d.bits   = 4'h0;
            d.sda_oe = 1'b0;
            d.shadow = i_time;
        end else if (bus_stop) begin
            // End of transfer, line released
            d.state  = rtcs_pkg::RTCS_IDLE;
            d.sda_oe = 1'b0;
        end else begin
            case (q.state)
                rtcs_pkg::RTCS_ADDR: begin
                    if (scl_rise) begin
                        d.sh   = {q.sh[6:0], sda_now};
                        d.bits = q.bits + 4'h1;
                    end
                    if (scl_fall && byte_done) begin
                        if (q.sh[7:1] == DEV_ADDR) begin
                            // Addressed: ack and note direction
                            d.state  = rtcs_pkg::RTCS_ACK;
                            d.sda_oe = 1'b1;
                            d.rd     = q.sh[0];
                            d.first  = ~q.sh[0];
                        end else begin
                            // Someone else's transfer
                            d.state = rtcs_pkg::RTCS_IGNORE;
                        end
                    end
                end
                rtcs_pkg::RTCS_RXD: begin
                    if (scl_rise) begin
                        d.sh   = {q.sh[6:0], sda_now};
                        d.bits = q.bits + 4'h1;
                    end
                    if (scl_fall && byte_done) begin
                        if (q.first) begin
                            // Pointer byte; upper bits unused
                            d.ptr   = q.sh[5:0];
                            d.first = 1'b0;
                        end else begin
                            // Data byte at the pointer
                            d.mem[q.ptr] = q.sh;
                            d.wr.valid   = 1'b1;
                            d.wr.addr    = q.ptr;
                            d.wr.data    = q.sh;
                            d.ptr        = q.ptr + 6'h01;
                        end
                        d.state  = rtcs_pkg::RTCS_ACK;
                        d.sda_oe = 1'b1;
                    end
                end
                rtcs_pkg::RTCS_ACK: begin
                    // Ack held until the ack clock falls
                    if (scl_fall) begin
                        d.bits = 4'h0;
                        if (q.rd) begin
                            // First read byte, MSB onto the line
                            d.sh     = rd_byte;
                            d.ptr    = q.ptr + 6'h01;
                            d.sda_oe = ~rd_byte[7];
                            d.state  = rtcs_pkg::RTCS_TXD;
                        end else begin
                            d.sda_oe = 1'b0;
                            d.state  = rtcs_pkg::RTCS_RXD;
                        end
                    end
                end
                rtcs_pkg::RTCS_TXD: begin
                    if (scl_rise) begin
                        d.bits = q.bits + 4'h1;
                    end
                    // Line only moves after the clock falls
                    if (scl_fall) begin
                        if (byte_done) begin
                            d.sda_oe = 1'b0;
                            d.state  = rtcs_pkg::RTCS_RACK;
                        end else begin
                            d.sh     = {q.sh[6:0], 1'b0};
                            d.sda_oe = ~q.sh[6];
                        end
                    end
                end
                rtcs_pkg::RTCS_RACK: begin
                    if (scl_rise) begin
                        d.nack = sda_now;
                    end
                    if (scl_fall) begin
                        if (q.nack) begin
                            // Leave line high so master can STOP
                            d.state = rtcs_pkg::RTCS_IGNORE;
                        end else begin
                            // Acked: send the next byte
                            d.bits   = 4'h0;
                            d.sh     = rd_byte;
                            d.ptr    = q.ptr + 6'h01;
                            d.sda_oe = ~rd_byte[7];
                            d.state  = rtcs_pkg::RTCS_TXD;
                        end
                    end
                end
                default: begin
                    // Idle or ignoring: line stays released
                    d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // Bus-side registers
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            q       <= '0;
            q.state <= rtcs_pkg::RTCS_IDLE;
            q.scl   <= 3'h7;
            q.sda   <= 3'h7;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops, drive value tied low; the line is only ever pulled low
    assign o_sda_o           = 1'b0;
    assign o_sda_oe          = q.sda_oe;
    assign o_wr              = q.wr;
    assign o_oscillator_halt = q.mem[0][`RTCS_HALT_BIT];

    // Control levels that cross to the oscillator domain
    assign ctl = {q.mem[0][`RTCS_HALT_BIT],
                  q.mem[`RTCS_CTRL_ADDR][`RTCS_CTRL_OUT],
                  q.mem[`RTCS_CTRL_ADDR][`RTCS_CTRL_SQUARE_WAVE_ENABLE],
                  q.mem[`RTCS_CTRL_ADDR][`RTCS_CTRL_RS_HI],
                  q.mem[`RTCS_CTRL_ADDR][`RTCS_CTRL_RS_LO]};
    assign osc_rst = s.rst[1];

    // Oscillator-side next state. Each control bit is a slow
    // level; a rate change may show one odd period while the
    // two select bits settle, which is harmless on this pin.
    always_comb begin
        n     = s;
        n.rst = {s.rst[0], i_rst};
        n.c1  = ctl;
        n.c2  = s.c1;
        if (osc_rst) begin
            n.cnt = 16'h0000;
            n.sqw = 1'b0;
        end else begin
            // A halted oscillator freezes the divider
            if (!s.c2[4]) begin
                n.cnt = s.cnt + 16'h0001;
            end
            if (s.c2[2]) begin
                case (s.c2[1:0])
                    2'h0:    n.sqw = s.cnt[`RTCS_TAP_1HZ];
                    2'h1:    n.sqw = s.cnt[`RTCS_TAP_4K];
                    2'h2:    n.sqw = s.cnt[`RTCS_TAP_8K];
                    default: n.sqw = s.cnt[`RTCS_TAP_32K];
                endcase
            end else begin
                n.sqw = s.c2[3];
            end
        end
    end

    // Oscillator-side registers
    always_ff @(posedge i_osc_clk) begin
        s <= n;
    end

    assign o_square_wave_pin = s.sqw;

    // ---- Checks ----
    start_enters_addr_a: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        bus_start |=> (q.state == rtcs_pkg::RTCS_ADDR) && (q.bits == 4'h0)
    ) else $error("START did not open address phase");

    stop_releases_a: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        bus_stop && !bus_start |=> (q.state == rtcs_pkg::RTCS_IDLE)
            && !o_sda_oe
    ) else $error("STOP did not end transfer");

    sda_when_low_a: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        $changed(o_sda_oe) |-> $past(scl_lo) || $past(bus_start)
            || $past(bus_stop)
    ) else $error("Data line moved while clock high");

    addr_ack_a: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (q.state == rtcs_pkg::RTCS_ADDR) && scl_fall && byte_done
            && (q.sh[7:1] == DEV_ADDR) && !bus_start && !bus_stop
            |=> o_sda_oe && (q.rd == $past(q.sh[0]))
    ) else $error("Matching address not acknowledged");

    addr_miss_a: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (q.state == rtcs_pkg::RTCS_ADDR) && scl_fall && byte_done
            && (q.sh[7:1] != DEV_ADDR) && !bus_start && !bus_stop
            |=> !o_sda_oe [*2]
    ) else $error("Foreign address acknowledged");

    ack_holds_a: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (q.state == rtcs_pkg::RTCS_ACK) && scl_rise && !bus_start
            |=> o_sda_oe throughout (!scl_fall [*3])
    ) else $error("Ack dropped during clock high");

    nack_release_a: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (q.state == rtcs_pkg::RTCS_RACK) && q.nack && scl_fall
            && !bus_start && !bus_stop
            |=> !o_sda_oe && (q.state == rtcs_pkg::RTCS_IGNORE)
    ) else $error("Line not released after not-ack");

    ptr_load_a: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (q.state == rtcs_pkg::RTCS_RXD) && q.first && scl_fall
            && byte_done && !bus_start && !bus_stop
            |=> (q.ptr == $past(q.sh[5:0])) && !o_wr.valid
    ) else $error("Pointer byte not loaded");

    ptr_wrap_a: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        o_wr.valid && (o_wr.addr == `RTCS_PTR_LAST) |-> q.ptr == 6'h00
    ) else $error("Pointer did not wrap");

    tx_msb_a: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        $rose(q.state == rtcs_pkg::RTCS_TXD) |-> o_sda_oe == !q.sh[7]
    ) else $error("First bit is not the MSB");

    shadow_copy_a: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        bus_start |=> q.shadow == $past(i_time)
    ) else $error("Shadow not loaded at START");

    sqw_level_a: assert property (
        @(posedge i_osc_clk) disable iff (osc_rst)
        !s.c2[2] |=> o_square_wave_pin == $past(s.c2[3])
    ) else $error("Disabled pin not at level bit");

    sqw_fast_a: assert property (
        @(posedge i_osc_clk) disable iff (osc_rst)
        s.c2[2] && (s.c2[1:0] == 2'h3)
            |=> o_square_wave_pin == $past(s.cnt[0])
    ) else $error("Fastest rate not selected");

    write_cov: cover property (
        @(posedge i_mclk) disable iff (i_rst) o_wr.valid);
    read_nack_cov: cover property (
        @(posedge i_mclk) disable iff (i_rst)
        (q.state == rtcs_pkg::RTCS_RACK) && q.nack && scl_fall);
    restart_cov: cover property (
        @(posedge i_mclk) disable iff (i_rst)
        bus_start && (q.state != rtcs_pkg::RTCS_IDLE));
    miss_cov: cover property (
        @(posedge i_mclk) disable iff (i_rst)
        $rose(q.state == rtcs_pkg::RTCS_IGNORE));

endmodule : rtcs_slave

// ### tb/rtcs_master.sv
// Bus master model: makes the bus clock and pulls the data line
`timescale 1ns/10ps

module rtcs_master #(
    parameter int HALF = 400            // Clock phase in system cycles
) (
    input  wire logic i_mclk,           // System clock
    input  wire logic i_sda,            // Resolved data line
    output logic      o_scl,            // Bus clock, master only
    output logic      o_sda             // 0 pulls low, 1 releases
);
    // Idle bus: both lines high until the first START
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    // All moves happen on falling system edges, away from sampling
    task automatic hw(input int n);
        repeat (n) @(negedge i_mclk);
    endtask : hw

    // START, or repeated START when the clock is low
    task automatic start();
        hw(HALF / 2);
        o_sda = 1'b1;
        hw(HALF / 2);
        o_scl = 1'b1;
        hw(HALF);
        o_sda = 1'b0;
        hw(HALF);
        o_scl = 1'b0;
    endtask : start

    // STOP: data rises while the clock is high
    task automatic stop();
        hw(HALF / 2);
        o_sda = 1'b0;
        hw(HALF / 2);
        o_scl = 1'b1;
        hw(HALF);
        o_sda = 1'b1;
        hw(HALF);
    endtask : stop

    // One pulse; data moves mid-low, line is read late in the high phase
    task automatic xbit(input logic b, output logic r);
        hw(HALF / 2);
        o_sda = b;
        hw(HALF / 2);
        o_scl = 1'b1;
        hw(HALF);
        r = i_sda;
        o_scl = 1'b0;
    endtask : xbit

    // Byte out MSB first, ninth pulse releases for the slave ack
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], r);
        xbit(1'b1, r);
        ack = ~r;
    endtask : wbyte

    // Byte in; the last one is not acknowledged
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
        xbit(last, r);
    endtask : rbyte
endmodule : rtcs_master

// ### tb/rtcs_slave_bench.sv
// Self-checking bench of the two-wire slave port
`timescale 1ns/10ps

module rtcs_slave_bench;
    localparam logic [6:0] ADDR = 7'h2a;  // Bus address, value arbitrary
    logic               i_mclk;           // System clock
    logic               i_rst;            // Sync reset
    logic               i_osc_clk;        // Oscillator tick
    logic               scl;              // Bus clock
    logic               m_sda;            // Master data drive
    logic               sda;              // Resolved data line
    logic               sda_o;            // Slave drive value
    logic               sda_oe;           // Slave pull enable
    logic [55:0]        i_time;           // Running time
    logic [55:0]        shadow;           // Time at START
    rtcs_pkg::rtcs_wr_s wr;               // Write strobe
    logic               halt;             // Halt bit
    logic               sqw;              // Square-wave pin
    logic [31:0]        seed;             // Xorshift state
    logic [5:0]         ptr;              // Reference pointer
    logic [7:0]         mem[64];          // Reference image
    logic [13:0]        wq[$];            // Seen write strobes
    logic [7:0]         c;                // Scratch byte
    logic [7:0]         rd;               // Read byte
    logic               a;                // Ack seen
    int                 n;                // Measured span
    int                 n_fail;           // Mismatches
    int                 total_checks;     // Comparisons
    int                 hp[4] = '{32768, 8, 4, 1}; // Half periods, ticks

    // Pull-up: a released line reads high
    assign sda = m_sda & (sda_oe ? sda_o : 1'b1);

    rtcs_slave #(.DEV_ADDR(ADDR)) u_rtcs_slave (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_osc_clk(i_osc_clk),
        .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
        .i_time(i_time), .o_wr(wr), .o_oscillator_halt(halt),
        .o_square_wave_pin(sqw));
    // Short bus phases keep the run short; the port samples every
    // system cycle, so only the order of line moves matters to it.
    rtcs_master #(.HALF(150)) u_rtcs_master (
        .i_mclk(i_mclk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));

    // Clocks; the oscillator is offset so the phases never line up
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    initial begin
        i_osc_clk = 1'b0;
        #1.7;
        forever #3 i_osc_clk = ~i_osc_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    // Collect every write strobe for later comparison
    always @(posedge i_mclk) begin
        if (wr.valid === 1'b1) begin
            wq.push_back({wr.addr, wr.data});
        end
    end

    // Address, pointer, then k bytes from the top of d
    task automatic bus_wr(input logic [5:0] p, input int k,
                          input logic [15:0] d);
        u_rtcs_master.start();
        u_rtcs_master.wbyte({ADDR, 1'b0}, a);
        check("addr ack", {15'h0, a}, 16'h1);
        u_rtcs_master.wbyte({2'b0, p}, a);
        check("ptr ack", {15'h0, a}, 16'h1);
        ptr = p;
        for (int i = k - 1; i >= 0; i--) begin
            u_rtcs_master.wbyte(d[8*i +: 8], a);
            check("data ack", {15'h0, a}, 16'h1);
            mem[ptr] = d[8*i +: 8];
            check("wr count", 16'(wq.size()), 16'h1);
            check("wr strobe", {2'b0, wq.pop_front()},
                  {2'b0, ptr, mem[ptr]});
            ptr = ptr + 6'h1;
        end
        u_rtcs_master.stop();
    endtask : bus_wr

    // Ticks between two pin changes, capped at 200
    task automatic sqw_span(output int s);
        logic p;
        int   k;
        repeat (8) @(posedge i_osc_clk);
        #1;
        p = sqw;
        k = 0;
        while (sqw === p && k < 200) begin
            @(posedge i_osc_clk);
            #1;
            k++;
        end
        p = sqw;
        s = 0;
        while (sqw === p && s < 200) begin
            @(posedge i_osc_clk);
            #1;
            s++;
        end
    endtask : sqw_span

    // A hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge i_mclk);
        n_fail++;
        finish_test();
    end

    // Main sequence
    initial begin
        seed = 32'h2d130ed4;
        n_fail = 0;
        total_checks = 0;
        i_rst = 1'b1;
        i_time = 56'({rnd(), rnd()});
        repeat (10) @(negedge i_mclk);
        i_rst = 1'b0;
        repeat (3) @(negedge i_mclk);
        check("halt reset", {15'h0, halt}, 16'h0);
        // Every rate code, undefined control bits random
        for (int r = 0; r < 4; r++) begin
            c = 8'(rnd());
            c[4] = 1'b1;
            c[1:0] = 2'(r);
            bus_wr(6'h07, 1, {8'h0, c});
            sqw_span(n);
            check("sqw span", 16'(n), 16'(hp[r] > 200 ? 200 : hp[r]));
        end
        // Disabled square wave shows the level bit
        c = {1'(rnd() >> 31), 7'h0};
        bus_wr(6'h07, 1, {8'h0, c});
        repeat (10) @(posedge i_osc_clk);
        check("sqw level", {15'h0, sqw}, {15'h0, c[7]});
        // Two bytes across the top of the map, halt bit set
        bus_wr(6'h3f, 2, 16'(rnd()) | 16'h0080);
        check("halt set", {15'h0, halt}, 16'h1);
        // Pointer write, repeated START, read across the wrap
        u_rtcs_master.start();
        u_rtcs_master.wbyte({ADDR, 1'b0}, a);
        u_rtcs_master.wbyte(8'h3f, a);
        u_rtcs_master.start();
        shadow = i_time;
        i_time = 56'({rnd(), rnd()});
        u_rtcs_master.wbyte({ADDR, 1'b1}, a);
        check("rd addr ack", {15'h0, a}, 16'h1);
        u_rtcs_master.rbyte(1'b0, rd);
        check("rd 3f", {8'h0, rd}, {8'h0, mem[63]});
        u_rtcs_master.rbyte(1'b1, rd);
        check("rd wrap", {8'h0, rd}, {8'h0, shadow[7:0]});
        repeat (5) @(negedge i_mclk);
        check("released", {15'h0, sda_oe}, 16'h0);
        u_rtcs_master.stop();
        // Read with no pointer write continues at 01
        u_rtcs_master.start();
        shadow = i_time;
        i_time = 56'({rnd(), rnd()});
        u_rtcs_master.wbyte({ADDR, 1'b1}, a);
        u_rtcs_master.rbyte(1'b1, rd);
        check("rd 01", {8'h0, rd}, {8'h0, shadow[15:8]});
        u_rtcs_master.stop();
        // Foreign address: no ack, following byte ignored
        u_rtcs_master.start();
        u_rtcs_master.wbyte({ADDR ^ (7'(rnd()) | 7'h01), 1'b0}, a);
        check("foreign ack", {15'h0, a}, 16'h0);
        u_rtcs_master.wbyte(8'(rnd()), a);
        check("ignored ack", {15'h0, a}, 16'h0);
        u_rtcs_master.stop();
        check("no strobe", 16'(wq.size()), 16'h0);
        finish_test();
    end
endmodule : rtcs_slave_bench
